// >>> logic/acp_map.svh
// Purpose: Offsets, fields, reset values and counts of the converter control.
// Assumes: Included by bare name after the package.
// Notes:   Counts are in sample clock cycles unless named otherwise.
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

// Register byte offsets.
`define ACP_CTRL_OFS   4'h0
`define ACP_STAT_OFS   4'h4

// Control register fields and reset value.
`define ACP_CTRL_FSS   0
`define ACP_CTRL_CDS   1
`define ACP_CTRL_OES   2
`define ACP_CTRL_RST   3'h0

// Status register fields.
`define ACP_STAT_RUN   0
`define ACP_STAT_PD    1
`define ACP_STAT_CALD  2
`define ACP_STAT_OOR   3
`define ACP_STAT_LVL   4
`define ACP_STAT_SPAN  16

// Full-scale spans in millivolts peak-to-peak.
`define ACP_SPAN_HI_MV 10'h320
`define ACP_SPAN_LO_MV 10'h258

// Least run of the command pin, length of a calibration, power-on delays.
`define ACP_RUN_MIN    4'hA
`define ACP_CAL_CYCLES 11'h400
`define ACP_DLY_SHORT  31'h0100_0000
`define ACP_DLY_LONG   31'h4000_0000

// Clock cycles after reset release before the straps are read.
`define ACP_INIT_WAIT  2'h3

`endif

// >>> logic/acp_pkg.sv
// Purpose: Types shared by the converter control files.
// Assumes: Nothing.
// Notes:   Numbers live in acp_map.svh.
package acp_pkg;

	typedef enum logic [2:0] {
		ST_INIT,
		ST_DELAY,
		ST_IDLE,
		ST_CAL,
		ST_PD
	} acp_state_e;

	typedef logic [7:0] acp_code_t;

endpackage : acp_pkg

// >>> logic/acp_fifo.sv
// Purpose: Small synchronous FIFO for converted words.
// Assumes: DEPTH is a power of two.
// Notes:   Full and empty come from pointers with one extra wrap bit.
`timescale 1ns/10ps
module acp_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	// Fill side.
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	// Drain side.
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [WIDTH-1:0]                out_data_o,
	output logic [$clog2(DEPTH):0]          level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW:0]      wptr_r;
	logic [AW:0]      rptr_r;
	logic             push;
	logic             pop;

	assign level_o     = wptr_r - rptr_r;
	assign out_valid_o = (wptr_r != rptr_r);
	assign in_ready_o  = (level_o != DEPTH[AW:0]);
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;
	assign out_data_o  = mem_r[rptr_r[AW-1:0]];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wptr_r[AW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (push) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (pop) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end

endmodule : acp_fifo

// >>> logic/acp_ctrl.sv
// Purpose: Calibration, power-down and output control of an 8-bit converter.
// Assumes: The sample clock arrives as a pin and is sampled by clk_i.
// Notes:   Every duration in the list below counts rising edges of the sample clock.
//
// Operation
// - Clipped result raises out-of-range pair.
// - Full-scale select picks 800 or 600 mV.
// - Calibrate after power-up and on command.
// - Calibration running flag high during calibration.
// - Power-on calibration waits a selectable delay.
// - Delay is 2^24 or 2^30 cycles.
// - Command high at power-up skips power-on calibration.
// - Calibration starts ten cycles after command high.
// - Power-down at power-up halts delay counter.
// - Edge select picks rising or falling data edge.
// - Power-down floats outputs in low-power state.
// - Stopped clock keeps last output code.
// - Running calibration finishes before power-down.
// - Commands ignored entirely while powered down.
// - No clock keeps analog powered down through power-on delay and calibration.
`timescale 1ns/10ps
`include "acp_map.svh"
module acp_ctrl
	import acp_pkg::*;
#(
	parameter logic [30:0] PON_DLY_SHORT = `ACP_DLY_SHORT,
	parameter logic [30:0] PON_DLY_LONG  = `ACP_DLY_LONG
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Register bus.
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Control pins.
	input  wire logic        samp_clk_i,
	input  wire logic        cal_cmd_i,
	input  wire logic        power_down_input_i,
	// Conversion results.
	input  wire logic [9:0]  conv_raw_i,
	input  wire logic        conv_valid_i,
	output logic             conv_ready_o,
	// Analog control.
	output logic             full_scale_select_o,
	output logic             analog_power_down_o,
	output logic             calibration_running_o,
	// Digital outputs.
	output logic             forwarded_data_clock_o,
	output acp_code_t        data_o,
	output logic             or_p_o,
	output logic             or_n_o,
	output logic             data_oe_o
);
	acp_state_e  st_r;
	logic [2:0]  sync1_r;
	logic [2:0]  sync2_r;
	logic        samp_d_r;
	logic        samp_rise;
	logic        samp_fall;
	logic        clk_seen_r;
	logic        cal_s;
	logic        pd_s;
	logic [1:0]  init_cnt_r;
	logic [3:0]  low_cnt_r;
	logic [3:0]  high_cnt_r;
	logic        armed_r;
	logic        cal_req_r;
	logic [30:0] dly_cnt_r;
	logic [30:0] dly_lim;
	logic        dly_done;
	logic [10:0] cal_cnt_r;
	logic        cal_done;
	logic        calibrated_r;
	logic        pd_active;
	logic [2:0]  ctrl_r;
	logic        ack_r;
	logic [31:0] rdata_r;
	logic [9:0]  span_mv;
	logic [8:0]  fifo_din;
	logic [8:0]  fifo_dout;
	logic        fifo_valid;
	logic        fifo_pop;
	logic [3:0]  fifo_lvl;
	logic        out_edge;
	logic        forwarded_data_clock_r;

	// The first stage feeds only the second, so no logic sees a metastable level.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {power_down_input_i, cal_cmd_i, samp_clk_i};
			sync2_r <= sync1_r;
		end
	end

	assign cal_s     = sync2_r[1];
	assign pd_s      = sync2_r[2];
	assign samp_rise = sync2_r[0] & ~samp_d_r;
	assign samp_fall = ~sync2_r[0] & samp_d_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			samp_d_r   <= 1'b0;
			clk_seen_r <= 1'b0;
		end else begin
			samp_d_r   <= sync2_r[0];
			clk_seen_r <= clk_seen_r | samp_rise;
		end
	end

	// Command filter: ten low edges arm it, the tenth high edge fires it.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			low_cnt_r  <= 4'h0;
			high_cnt_r <= 4'h0;
			armed_r    <= 1'b0;
			cal_req_r  <= 1'b0;
		end else begin
			cal_req_r <= 1'b0;
			if (st_r == ST_PD) begin
				armed_r <= 1'b0;
			end
			if (samp_rise) begin
				if (!cal_s) begin
					high_cnt_r <= 4'h0;
					if (low_cnt_r != `ACP_RUN_MIN) begin
						low_cnt_r <= low_cnt_r + 4'h1;
					end
					if (low_cnt_r == `ACP_RUN_MIN - 4'h1 && st_r != ST_PD) begin
						armed_r <= 1'b1;
					end
				end else begin
					low_cnt_r <= 4'h0;
					if (high_cnt_r != `ACP_RUN_MIN) begin
						high_cnt_r <= high_cnt_r + 4'h1;
					end
					if (high_cnt_r == `ACP_RUN_MIN - 4'h1 && armed_r && st_r != ST_PD) begin
						cal_req_r <= 1'b1;
						armed_r   <= 1'b0;
					end
				end
			end
		end
	end

	assign dly_lim  = ctrl_r[`ACP_CTRL_CDS] ? PON_DLY_LONG : PON_DLY_SHORT;
	assign dly_done = samp_rise && !pd_s && (dly_cnt_r == dly_lim - 31'h1);
	assign cal_done = samp_rise && (cal_cnt_r == `ACP_CAL_CYCLES - 11'h1);

	// Power-on delay halts while power-down is held.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			dly_cnt_r <= 31'h0;
		end else if (st_r == ST_DELAY && samp_rise && !pd_s) begin
			dly_cnt_r <= dly_cnt_r + 31'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cal_cnt_r <= 11'h0;
		end else if (st_r != ST_CAL) begin
			cal_cnt_r <= 11'h0;
		end else if (samp_rise) begin
			cal_cnt_r <= cal_cnt_r + 11'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			init_cnt_r <= 2'h0;
		end else if (st_r == ST_INIT) begin
			init_cnt_r <= init_cnt_r + 2'h1;
		end
	end

	// The straps are read once the synchronisers hold pin levels.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			st_r         <= ST_INIT;
			calibrated_r <= 1'b0;
		end else begin
			unique case (st_r)
				ST_INIT: begin
					if (init_cnt_r == `ACP_INIT_WAIT) begin
						st_r <= cal_s ? ST_IDLE : ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (dly_done || (cal_req_r && !pd_s)) begin
						st_r <= ST_CAL;
					end
				end
				ST_IDLE: begin
					if (pd_s) begin
						st_r <= ST_PD;
					end else if (cal_req_r) begin
						st_r <= ST_CAL;
					end
				end
				ST_CAL: begin
					if (cal_done) begin
						calibrated_r <= 1'b1;
						st_r         <= pd_s ? ST_PD : ST_IDLE;
					end
				end
				ST_PD: begin
					if (!pd_s) begin
						st_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	assign pd_active             = (st_r == ST_PD) || (st_r == ST_DELAY && pd_s);
	assign calibration_running_o = (st_r == ST_CAL);
	// Without a sample clock the pending power-on sequence holds analog power off.
	assign analog_power_down_o   = pd_active ||
		(!clk_seen_r && st_r inside {ST_INIT, ST_DELAY, ST_CAL});
	assign full_scale_select_o   = ctrl_r[`ACP_CTRL_FSS];
	assign span_mv = ctrl_r[`ACP_CTRL_FSS] ? `ACP_SPAN_HI_MV : `ACP_SPAN_LO_MV;

	// Results outside 00h..FFh are clipped and flagged with them.
	assign fifo_din = conv_raw_i[9] ? {1'b1, 8'h00} :
		conv_raw_i[8] ? {1'b1, 8'hFF} : {1'b0, conv_raw_i[7:0]};

	logic fifo_in_ready;
	assign conv_ready_o = fifo_in_ready & ~pd_active;

	acp_fifo #(
		.WIDTH (9),
		.DEPTH (8)
	) u_fifo (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (conv_valid_i & ~pd_active),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (fifo_din),
		.out_valid_o (fifo_valid),
		.out_ready_i (out_edge & ~pd_active),
		.out_data_o  (fifo_dout),
		.level_o     (fifo_lvl)
	);

	// Data leave on the forwarded clock edge chosen by software.
	assign out_edge = ctrl_r[`ACP_CTRL_OES] ? samp_rise : samp_fall;
	assign fifo_pop = out_edge & fifo_valid & ~pd_active;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			forwarded_data_clock_r <= 1'b0;
		end else begin
			forwarded_data_clock_r <= sync2_r[0];
		end
	end

	// Output registers only move on a pop, so a stopped clock keeps the code.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			data_o <= 8'h00;
			or_p_o <= 1'b0;
			or_n_o <= 1'b1;
		end else if (fifo_pop) begin
			data_o <= fifo_dout[7:0];
			or_p_o <= fifo_dout[8];
			or_n_o <= ~fifo_dout[8];
		end
	end

	assign forwarded_data_clock_o = forwarded_data_clock_r;
	assign data_oe_o              = ~pd_active;

	// One wait state: each request is answered at the second edge.
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
	assign avs_readdata_o    = rdata_r;

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read_i | avs_write_i) & ~ack_r;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl_r <= `ACP_CTRL_RST;
		end else if (avs_write_i && ack_r && avs_address_i == `ACP_CTRL_OFS
			&& avs_byteenable_i[0]) begin
			ctrl_r <= avs_writedata_i[2:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rdata_r <= 32'h0000_0000;
		end else if (avs_read_i && !ack_r) begin
			rdata_r <= 32'h0000_0000;
			if (avs_address_i == `ACP_CTRL_OFS) begin
				rdata_r[2:0] <= ctrl_r;
			end else if (avs_address_i == `ACP_STAT_OFS) begin
				rdata_r[`ACP_STAT_RUN]                 <= calibration_running_o;
				rdata_r[`ACP_STAT_PD]                  <= pd_active;
				rdata_r[`ACP_STAT_CALD]                <= calibrated_r;
				rdata_r[`ACP_STAT_OOR]                 <= or_p_o;
				rdata_r[`ACP_STAT_LVL+:4]              <= fifo_lvl;
				rdata_r[`ACP_STAT_SPAN+:10]            <= span_mv;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	oor_pair_a: assert property (fifo_pop |=> or_p_o == $past(fifo_dout[8])
		&& or_n_o == !or_p_o) else $error("out-of-range pair wrong");
	span_sel_a: assert property (full_scale_select_o |-> span_mv == 10'h320)
		else $error("span does not follow select");
	cmd_cal_a: assert property (cal_req_r && st_r == ST_IDLE && !pd_s |=> st_r == ST_CAL)
		else $error("command did not start calibration");
	cal_len_a: assert property ($fell(calibration_running_o) |->
		$past(cal_cnt_r) == 11'h3FF) else $error("calibration ended early");
	pon_start_a: assert property (st_r == ST_DELAY ##1 st_r == ST_CAL |->
		$past(dly_done) || $past(cal_req_r)) else $error("delay cut short");
	strap_skip_a: assert property (st_r == ST_INIT && init_cnt_r == 2'h3 && cal_s
		|=> st_r == ST_IDLE && !calibrated_r) else $error("strap ignored");
	cmd_filter_a: assert property (cal_req_r |-> high_cnt_r == 4'hA)
		else $error("command fired before ten high edges");
	dly_halt_a: assert property (st_r == ST_DELAY && pd_s |=> $stable(dly_cnt_r))
		else $error("delay counted in power-down");
	edge_sel_a: assert property (fifo_pop |=> forwarded_data_clock_r == $past(ctrl_r[2]))
		else $error("data changed on wrong edge");
	pd_float_a: assert property (st_r == ST_PD |-> !data_oe_o && analog_power_down_o)
		else $error("outputs driven in power-down");
	code_hold_a: assert property (!fifo_pop |=> $stable(data_o))
		else $error("code moved without an edge");
	cal_finish_a: assert property (st_r == ST_CAL && !cal_done |=> st_r == ST_CAL)
		else $error("calibration cut short");
	pd_ignore_a: assert property (st_r == ST_PD ##1 st_r == ST_PD |-> !cal_req_r)
		else $error("command accepted in power-down");
	noclk_off_a: assert property (!clk_seen_r && st_r == ST_DELAY |-> analog_power_down_o)
		else $error("analog powered without clock");

	cmd_cal_c:  cover property (st_r == ST_IDLE && cal_req_r ##1 st_r == ST_CAL);
	pd_cal_c:   cover property (st_r == ST_CAL && pd_s && cal_done ##1 st_r == ST_PD);
	fifo_full_c: cover property (!fifo_in_ready && !pd_active);

endmodule : acp_ctrl

// >>> test/acp_partner.sv
// Purpose: Far side model: sample clock source and capture logic.
// Assumes: The receiver latches on the edge opposite the data change.
// Notes:   The clock stands low while run_i is low, like a stopped source.
`timescale 1ns/10ps
module acp_partner (
	// Clock source control.
	input  wire logic       run_i,
	input  wire logic       edge_sel_i,
	output logic            samp_clk_o,
	// Captured pins.
	input  wire logic       forwarded_data_clock_i,
	input  wire logic       oe_i,
	input  wire logic [9:0] pins_i,
	output logic [9:0]      cap_o
);
	initial begin
		samp_clk_o = 1'b0;
		cap_o      = 10'h000;
		forever begin
			#62.5;
			samp_clk_o = run_i ? ~samp_clk_o : 1'b0;
		end
	end

	// Latching half a period after the change keeps clear of pin skew.
	always @(forwarded_data_clock_i) begin
		if (oe_i === 1'b1 && forwarded_data_clock_i !== edge_sel_i) begin
			cap_o <= pins_i;
		end
	end
endmodule : acp_partner

// >>> test/acp_ctrl_tb.sv
// Purpose: Self-checking bench of the converter control.
// Assumes: Power-on delays shortened to 20 and 40 sample cycles.
// Notes:   One calibration costs about 32000 system cycles.
`timescale 1ns/10ps
module acp_ctrl_tb
	import acp_pkg::*;
;
	logic        clk_i;
	logic        resetn_i = 1'b0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic        cal = 1'b0;
	logic        pd = 1'b0;
	logic        cv = 1'b0;
	logic        run = 1'b0;
	logic        esel = 1'b0;
	logic        mon = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rdw;
	logic [9:0]  raw = 10'h000;
	logic [9:0]  cap;
	logic [9:0]  snap;
	logic        samp, wreq, cready, fss, apd, crun, forwarded_data_clock, orp, orn, oe;
	logic        pdclk;
	acp_code_t   dat;
	acp_code_t   pdat;
	int          fail_count = 0;
	int          tests_run = 0;
	int          n;
	localparam logic [9:0] RV [6] = '{10'h120, 10'h3FB, 10'h07F, 10'h100, 10'h000, 10'h0FF};

	acp_ctrl #(.PON_DLY_SHORT(31'h14), .PON_DLY_LONG(31'h28)) dut (
		.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdw), .avs_waitrequest_o(wreq), .samp_clk_i(samp),
		.cal_cmd_i(cal), .power_down_input_i(pd), .conv_raw_i(raw), .conv_valid_i(cv),
		.conv_ready_o(cready), .full_scale_select_o(fss), .analog_power_down_o(apd),
		.calibration_running_o(crun), .forwarded_data_clock_o(forwarded_data_clock), .data_o(dat),
		.or_p_o(orp), .or_n_o(orn), .data_oe_o(oe));

	acp_partner u_far (.run_i(run), .edge_sel_i(esel), .samp_clk_o(samp), .forwarded_data_clock_i(forwarded_data_clock),
		.oe_i(oe), .pins_i({orp, orn, dat}), .cap_o(cap));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic rng(input string nm, input int lo, input int hi, input int g);
		tests_run++;
		if (g < lo || g > hi) begin
			fail_count++;
			$display("[ERR] %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : rng

	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			fail_count++;
			$display("[ERR] wait exp answer got timeout");
			finish_test();
		end
	endtask : tmo

	// The request is held until the edge that sees waitrequest low.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		adr <= a;
		wdat <= d;
		wr <= w;
		rd <= ~w;
		#1;
		while (wreq !== 1'b0 && k < 50) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		tmo(k, 50);
		@(posedge clk_i);
		rdat = rdw;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus

	task automatic push(input logic [9:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		raw <= r;
		cv <= 1'b1;
		#1;
		while (cready !== 1'b1 && k < 50) begin
			@(posedge clk_i);
			#1;
			k++;
		end
		tmo(k, 50);
		@(posedge clk_i);
		cv <= 1'b0;
	endtask : push

	task automatic wrun(input logic v, input int lim);
		n = 0;
		#1;
		while (crun !== v && n < lim) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		tmo(n, lim);
	endtask : wrun

	task automatic sw(input int k);
		repeat (k) @(posedge samp);
		@(posedge clk_i);
	endtask : sw

	task automatic rst(input logic c, input logic p);
		@(posedge clk_i);
		resetn_i <= 1'b0;
		cal <= c;
		pd <= p;
		run <= 1'b1;
		repeat (4) @(posedge clk_i);
		resetn_i <= 1'b1;
	endtask : rst

	function automatic logic [9:0] exp_pins(input logic [9:0] r);
		if (r[9]) begin
			return 10'h200;
		end
		if (r[8]) begin
			return 10'h2FF;
		end
		return {2'b01, r[7:0]};
	endfunction : exp_pins

	// Values are seen before the edge, so a change and its clock move line up.
	always @(posedge clk_i) begin
		pdclk <= forwarded_data_clock;
		pdat <= dat;
		if (mon && dat !== pdat) begin
			chk("data edge", {31'h0, esel}, {31'h0, forwarded_data_clock});
			chk("forwarded_data_clock moved", 32'h1, {31'h0, forwarded_data_clock !== pdclk});
		end
	end

	initial begin
		rst(1'b1, 1'b0);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl reset", 32'h0, rdat);
		bus(1'b1, 4'h0, 32'h7);
		bus(1'b0, 4'h0, 32'h0);
		chk("ctrl", 32'h7, rdat);
		chk("fss pin", 32'h1, {31'h0, fss});
		bus(1'b0, 4'h4, 32'h0);
		chk("span hi", 32'h320, {22'h0, rdat[25:16]});
		bus(1'b1, 4'h8, 32'hFF);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", 32'h0, rdat);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b0, 4'h4, 32'h0);
		chk("span lo", 32'h258, {22'h0, rdat[25:16]});
		sw(60);
		bus(1'b0, 4'h4, 32'h0);
		chk("no pon cal", 32'h0, {29'h0, rdat[2:0]});
		$display("test regs done");
		mon = 1'b1;
		for (int e = 0; e < 2; e++) begin
			esel = e[0];
			bus(1'b1, 4'h0, {29'h0, esel, 2'h0});
			foreach (RV[i]) begin
				push(RV[i]);
				sw(3);
				chk("capture", {22'h0, exp_pins(RV[i])}, {22'h0, cap});
			end
		end
		// A stopped source is the stall that lets the buffer fill.
		run <= 1'b0;
		repeat (100) @(posedge clk_i);
		snap = {orp, orn, dat};
		cv <= 1'b1;
		raw <= 10'h010;
		n = 0;
		for (int i = 0; i < 20; i++) begin
			#1;
			if (cready === 1'b1) begin
				n++;
			end
			@(posedge clk_i);
			raw <= 10'h010 + 10'(n);
		end
		cv <= 1'b0;
		chk("fifo accepts", 32'h8, 32'(n));
		bus(1'b0, 4'h4, 32'h0);
		chk("fifo level", 32'h8, {28'h0, rdat[7:4]});
		chk("held code", {22'h0, snap}, {22'h0, orp, orn, dat});
		chk("held drive", 32'h1, {31'h0, oe});
		run <= 1'b1;
		// Restarting the source drains the eight buffered words within twelve edges.
		sw(12);
		bus(1'b0, 4'h4, 32'h0);
		chk("fifo drained", 32'h0, {28'h0, rdat[7:4]});
		chk("last word", 32'h117, {22'h0, orp, orn, dat});
		mon = 1'b0;
		$display("test data done");
		rst(1'b0, 1'b1);
		sw(60);
		chk("halted", 32'h0, {31'h0, crun});
		chk("floated", 32'h0, {31'h0, oe});
		chk("analog off", 32'h1, {31'h0, apd});
		bus(1'b1, 4'h0, 32'h2);
		pd <= 1'b0;
		wrun(1'b1, 3000);
		rng("pon delay", 1200, 1320, n);
		@(posedge clk_i);
		pd <= 1'b1;
		wrun(1'b0, 34000);
		rng("cal length", 31800, 32100, n);
		repeat (10) @(posedge clk_i);
		bus(1'b0, 4'h4, 32'h0);
		chk("pd after cal", 32'h6, {29'h0, rdat[2:0]});
		cal <= 1'b0;
		sw(12);
		cal <= 1'b1;
		sw(15);
		chk("pd ignores cmd", 32'h0, {31'h0, crun});
		pd <= 1'b0;
		sw(20);
		chk("no late cal", 32'h0, {31'h0, crun});
		chk("driven", 32'h1, {31'h0, oe});
		cal <= 1'b0;
		sw(12);
		cal <= 1'b1;
		wrun(1'b1, 1000);
		rng("cmd latency", 275, 330, n);
		bus(1'b0, 4'h4, 32'h0);
		chk("run flag", 32'h1, {31'h0, rdat[0]});
		$display("test power done");
		finish_test();
	end
endmodule : acp_ctrl_tb
